/* File: snv_defs.svh */
/*
  shared constants of the serial nonvolatile memory block: command codes,
  status bit positions, protect boundaries, sizes and fifo depth.
  assumes it is included by bare name from package and design files.
*/
`ifndef SNV_DEFS_SVH
`define SNV_DEFS_SVH

`define SNV_CMD_SET_LATCH    8'h06
`define SNV_CMD_CLR_LATCH    8'h04
`define SNV_CMD_STATUS_RD    8'h05
`define SNV_CMD_STATUS_WR    8'h01
`define SNV_CMD_MEM_RD_LOW   3'h3
`define SNV_CMD_MEM_WR_LOW   3'h2
`define SNV_CMD_ADDR_BIT     3
`define SNV_SR_LATCH_BIT     1
`define SNV_SR_BP_LO_BIT     2
`define SNV_SR_BP_HI_BIT     3
`define SNV_BP_RESET         2'h0
`define SNV_PROT_QUARTER     9'h180
`define SNV_PROT_HALF        9'h100
`define SNV_MEM_DEPTH        512
`define SNV_ADDR_W           9
`define SNV_FIFO_DEPTH       8
`define SNV_FIFO_AW          3

`endif

/* File: snv_pkg.sv */
/*
  types of the serial nonvolatile memory block.
  assumes snv_defs.svh is on the include path.
*/
`include "snv_defs.svh"

package snv_pkg;

  typedef enum logic [2:0] {
    SNV_ST_CMD    = 3'h0,
    SNV_ST_ADDR   = 3'h1,
    SNV_ST_MEM_WR = 3'h2,
    SNV_ST_MEM_RD = 3'h3,
    SNV_ST_SR_WR  = 3'h4,
    SNV_ST_SR_RD  = 3'h5,
    SNV_ST_IDLE   = 3'h6
  } snv_state_e;

  typedef struct packed {
    logic [`SNV_ADDR_W-1:0] addr;
    logic [7:0]             data;
  } snv_wr_s;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } snv_pins_s;

endpackage : snv_pkg

/* File: snv_fifo.sv */
/*
  small flop-based fifo with valid/ready on both sides.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`include "snv_defs.svh"

module snv_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = `SNV_FIFO_DEPTH,
  parameter int AW    = `SNV_FIFO_AW
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg, wr_ptr_next;
  logic [AW:0]      rd_ptr_reg, rd_ptr_next;
  logic             push, pop;

  // extra pointer bit tells full from empty
  always_comb begin
    push        = i_in_valid && o_in_ready;
    pop         = o_out_valid && i_out_ready;
    wr_ptr_next = wr_ptr_reg + (AW+1)'(push);
    rd_ptr_next = rd_ptr_reg + (AW+1)'(pop);
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // storage has no reset: contents are don't-care while empty
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  assign o_in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                         (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign o_out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign o_out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

endmodule : snv_fifo

/* File: snv_core.sv */
/*
  spi-side access and write protection of a 512 x 8 nonvolatile memory.
  all pins are sampled by i_clk (20 MHz), which must run well above sck.
  accepted bytes pass an 8-word fifo before they reach the array.
*/
//
// Contract
// - a set-write-latch command must precede every array or status write
// - write-protect low blocks every array and status write
// - write-protect high lets block-protect bits decide array writes
// - status bits 0 and 4..7 read zero and ignore writes
// - status bit 0, the legacy ready bit, is tied low
// - both block-protect bits are nonvolatile and survive power cycles
// - bit 1 shows latch; set/clear commands; select rise after write clears
// - protect codes: none, 180h-1FFh, 100h-1FFh, whole array
// - block-protect applies only with write-protect high and latch set
// - latch clear or write-protect low protects everything incl. status
// - command bit 3 carries address bit 8
// - one address byte follows a memory command, forming 9 bits
// - each written byte commits after its 8th clock, no page limit
// - address increments per byte and wraps 1FFh to 000h
// - select rising ends a write; no more data is accepted
// - reads ignore input and shift out msb first, 8 clocks per byte
// - reads continue byte after byte until select rises
// - hold low while clock low pauses the operation intact
// - hold high while clock low resumes; clocks during hold ignored
// - set latch is 06h, clear latch is 04h
// - status read 05h returns a byte, status write 01h takes one
// - memory read 0000_A011b, memory write 0000_A010b
// - bytes msb first, sample on rising, drive on falling clock
`timescale 1ns/1ps
`include "snv_defs.svh"

module snv_core (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire snv_pkg::snv_pins_s i_pins,
  output logic                  o_so,
  output logic                  o_so_oe_n,
  output logic [7:0]            o_status
);
  import snv_pkg::*;

  // three-stage synchronisers; stage 1 is read only by stage 2
  snv_pins_s  s1_reg, s2_reg, s3_reg;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b0};
      s2_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b0};
      s3_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b0};
    end else begin
      s1_reg <= i_pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // filtered levels: update only when stages 2 and 3 agree
  snv_pins_s  lvl_reg, lvl_next;
  always_comb begin
    lvl_next = lvl_reg;
    if (s2_reg.cs_n == s3_reg.cs_n)     lvl_next.cs_n   = s3_reg.cs_n;
    if (s2_reg.sck == s3_reg.sck)       lvl_next.sck    = s3_reg.sck;
    if (s2_reg.si == s3_reg.si)         lvl_next.si     = s3_reg.si;
    if (s2_reg.hold_n == s3_reg.hold_n) lvl_next.hold_n = s3_reg.hold_n;
    if (s2_reg.wp_n == s3_reg.wp_n)     lvl_next.wp_n   = s3_reg.wp_n;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lvl_reg <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b0};
    end else begin
      lvl_reg <= lvl_next;
    end
  end

  // hold edges count only while sck is low
  logic       hold_act_reg, hold_act_next;
  always_comb begin
    hold_act_next = hold_act_reg;
    if (!lvl_reg.sck && !lvl_reg.hold_n) hold_act_next = 1'b1;
    if (!lvl_reg.sck && lvl_reg.hold_n)  hold_act_next = 1'b0;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_act_reg <= 1'b0;
    end else begin
      hold_act_reg <= hold_act_next;
    end
  end

  // edges count only inside a frame and outside a hold; edges seen during a hold are lost
  logic sck_rise, sck_fall, run;
  assign run      = !lvl_reg.cs_n && !hold_act_reg;
  assign sck_rise = run && lvl_next.sck && !lvl_reg.sck;
  assign sck_fall = run && !lvl_next.sck && lvl_reg.sck;

  // protected when the address lies in the block-protect range
  function automatic logic addr_locked(input logic [1:0] bp,
                                       input logic [`SNV_ADDR_W-1:0] a);
    case (bp)
      2'h0:    addr_locked = 1'b0;
      2'h1:    addr_locked = (a >= `SNV_PROT_QUARTER);
      2'h2:    addr_locked = (a >= `SNV_PROT_HALF);
      default: addr_locked = 1'b1;
    endcase
  endfunction : addr_locked

  // burst address step; 9-bit arithmetic makes 1FFh roll to 000h
  function automatic logic [`SNV_ADDR_W-1:0] addr_step(input logic [`SNV_ADDR_W-1:0] a);
    addr_step = a + 9'h001;
  endfunction : addr_step

  // memory opcodes: upper nibble zero, low bits pick read or write, bit 3 is address_msb
  function automatic logic mem_opcode(input logic [7:0] op);
    mem_opcode = (op[7:4] == 4'h0) &&
                 (op[2:0] == `SNV_CMD_MEM_RD_LOW || op[2:0] == `SNV_CMD_MEM_WR_LOW);
  endfunction : mem_opcode

  // protocol state, latch, protect bits and output staging
  snv_state_e              st_reg, st_next;
  logic [7:0]              sh_reg, sh_next;
  logic [2:0]              cnt_reg, cnt_next;
  logic [`SNV_ADDR_W-1:0]  addr_reg, addr_next;
  logic                    rd_cmd_reg, rd_cmd_next;
  logic                    latch_reg, latch_next;
  logic [1:0]              bp_reg, bp_next;
  logic                    wr_done_reg, wr_done_next;
  logic [7:0]              obuf_reg, obuf_next;
  logic                    so_reg, so_next;
  logic                    oe_n_reg, oe_n_next;
  logic [7:0]              status;
  logic [7:0]              rd_data;
  logic [7:0]              byte_in;
  logic                    wr_ok;
  logic                    fifo_valid, fifo_ready, drain_valid;
  snv_wr_s                 fifo_in, fifo_out;
  logic [7:0]              mem_reg [`SNV_MEM_DEPTH];

  // only latch and block-protect bits are live
  always_comb begin
    status = 8'h00;
    status[`SNV_SR_LATCH_BIT] = latch_reg;
    status[`SNV_SR_BP_LO_BIT] = bp_reg[0];
    status[`SNV_SR_BP_HI_BIT] = bp_reg[1];
  end

  // incoming byte, write permission and the next byte of a read burst
  assign byte_in = {sh_reg[6:0], lvl_reg.si};
  assign wr_ok   = latch_reg && lvl_reg.wp_n;
  assign rd_data = mem_reg[addr_step(addr_reg)];

  // serial protocol engine; one opcode per select
  always_comb begin
    st_next      = st_reg;
    sh_next      = sh_reg;
    cnt_next     = cnt_reg;
    addr_next    = addr_reg;
    rd_cmd_next  = rd_cmd_reg;
    latch_next   = latch_reg;
    bp_next      = bp_reg;
    wr_done_next = wr_done_reg;
    obuf_next    = obuf_reg;
    so_next      = so_reg;
    oe_n_next    = oe_n_reg;
    fifo_valid   = 1'b0;
    fifo_in      = '{addr: addr_reg, data: byte_in};
    // select high: frame over; a completed write byte drops the latch
    if (lvl_reg.cs_n) begin
      st_next   = SNV_ST_CMD;
      cnt_next  = 3'h0;
      oe_n_next = 1'b1;
      if (wr_done_reg) latch_next = 1'b0;
      wr_done_next = 1'b0;
    end else begin
      // release the output at once on hold, not a cycle late
      oe_n_next = hold_act_next || !(st_reg == SNV_ST_MEM_RD || st_reg == SNV_ST_SR_RD);
      // shift in on each rise; the byte boundary is the rise at count 7
      if (sck_rise) begin
        sh_next  = byte_in;
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == 3'h7) begin
          // one action per completed byte, chosen by the frame phase
          case (st_reg)
            SNV_ST_CMD: begin
              st_next = SNV_ST_IDLE;
              if (byte_in == `SNV_CMD_SET_LATCH) latch_next = 1'b1;
              if (byte_in == `SNV_CMD_CLR_LATCH) latch_next = 1'b0;
              if (byte_in == `SNV_CMD_STATUS_RD) begin
                st_next   = SNV_ST_SR_RD;
                obuf_next = status;
              end
              if (byte_in == `SNV_CMD_STATUS_WR) st_next = SNV_ST_SR_WR;
              if (mem_opcode(byte_in)) begin
                st_next     = SNV_ST_ADDR;
                rd_cmd_next = byte_in[0];
                addr_next   = {byte_in[`SNV_CMD_ADDR_BIT], 8'h00};
              end
            end
            SNV_ST_ADDR: begin
              addr_next = {addr_reg[8], byte_in};
              st_next   = rd_cmd_reg ? SNV_ST_MEM_RD : SNV_ST_MEM_WR;
              if (rd_cmd_reg) obuf_next = mem_reg[{addr_reg[8], byte_in}];
            end
            SNV_ST_MEM_WR: begin
              // commit each byte, drop protected ones
              if (wr_ok && fifo_ready && !addr_locked(bp_reg, addr_reg))
                fifo_valid = 1'b1;
              // a dropped byte still ends a write, so the latch clears
              wr_done_next = 1'b1;
              addr_next = addr_step(addr_reg);
            end
            SNV_ST_SR_WR: begin
              // refused by the same latch and pin as the array
              if (wr_ok)
                bp_next = {byte_in[`SNV_SR_BP_HI_BIT],
                           byte_in[`SNV_SR_BP_LO_BIT]};
              wr_done_next = 1'b1;
              st_next = SNV_ST_IDLE;
            end
            SNV_ST_MEM_RD: begin
              addr_next = addr_step(addr_reg);
              obuf_next = rd_data;
            end
            default: st_next = SNV_ST_IDLE;
          endcase
        end
      end
      // drive on falling edges, msb first, input ignored
      if (sck_fall && (st_reg == SNV_ST_MEM_RD || st_reg == SNV_ST_SR_RD)) begin
        so_next = obuf_reg[3'h7 - cnt_reg];
        if (st_reg == SNV_ST_SR_RD && cnt_reg == 3'h0) so_next = status[7];
      end
    end
  end

  // protocol registers; the latch comes up clear after power-on reset
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg       <= SNV_ST_CMD;
      sh_reg       <= 8'h00;
      cnt_reg      <= 3'h0;
      addr_reg     <= 9'h000;
      rd_cmd_reg   <= 1'b0;
      latch_reg    <= 1'b0;                                      // power-up disabled
      wr_done_reg  <= 1'b0;
      obuf_reg     <= 8'h00;
      so_reg       <= 1'b0;
      oe_n_reg     <= 1'b1;
    end else begin
      st_reg       <= st_next;
      sh_reg       <= sh_next;
      cnt_reg      <= cnt_next;
      addr_reg     <= addr_next;
      rd_cmd_reg   <= rd_cmd_next;
      latch_reg    <= latch_next;
      wr_done_reg  <= wr_done_next;
      obuf_reg     <= obuf_next;
      so_reg       <= so_next;
      oe_n_reg     <= oe_n_next;
    end
  end

  // block-protect bits have no reset, modelling nonvolatile cells
  always_ff @(posedge i_clk) begin
    bp_reg <= bp_next;
  end

  // write buffer; drained every cycle, so it never fills and no byte is dropped for lack of room
  snv_fifo #(
    .WIDTH ($bits(snv_wr_s)),
    .DEPTH (`SNV_FIFO_DEPTH),
    .AW    (`SNV_FIFO_AW)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (fifo_valid),
    .o_in_ready  (fifo_ready),
    .i_in_data   (fifo_in),
    .o_out_valid (drain_valid),
    .i_out_ready (1'b1),
    .o_out_data  (fifo_out)
  );

  // array is nonvolatile too: no reset
  always_ff @(posedge i_clk) begin
    if (drain_valid) mem_reg[fifo_out.addr] <= fifo_out.data;
  end

  // registered status mirror; protect bits read zero during reset only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status <= 8'h00;
    end else begin
      o_status <= status;
    end
  end

  // serial output pins straight from flops
  assign o_so      = so_reg;
  assign o_so_oe_n = oe_n_reg;

endmodule : snv_core

/* File: snv_core_monitor.sv */
/*
  concurrent checks on the pins and status mirror of snv_core.
  assumes one i_clk domain and the active-low asynchronous i_rstn.
*/
`timescale 1ns/1ps

module snv_core_monitor (
  input wire logic               i_clk,
  input wire logic               i_rstn,
  input wire snv_pkg::snv_pins_s i_pins,
  input wire logic               o_so,
  input wire logic               o_so_oe_n,
  input wire logic [7:0]         o_status
);
  import snv_pkg::*;

  logic       sck_prev_reg;
  logic       sck_prev_next;
  logic [3:0] fall_age_reg;
  logic [3:0] fall_age_next;

  // age of the last sck fall, saturating so idle time never wraps round
  always_comb begin
    sck_prev_next = i_pins.sck;
    fall_age_next = (fall_age_reg == 4'hf) ? fall_age_reg : fall_age_reg + 4'h1;
    if (sck_prev_reg && !i_pins.sck) begin
      fall_age_next = 4'h0;
    end
  end

  // helper registers only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_prev_reg <= 1'b0;
      fall_age_reg <= 4'hf;
    end else begin
      sck_prev_reg <= sck_prev_next;
      fall_age_reg <= fall_age_next;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_fixed_bits_zero: assert property (o_status[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_ready_bit_low: assert property (!o_status[0])
    else $error("status ready bit not low");
  a_oe_off_idle: assert property (i_pins.cs_n [*6] |-> o_so_oe_n)
    else $error("output enabled while deselected");
  a_oe_off_hold: assert property ((!i_pins.hold_n) [*6] |-> o_so_oe_n)
    else $error("output enabled during hold");
  a_bp_wp_lock: assert property ((!i_pins.wp_n) [*6] |-> $stable(o_status[3:2]))
    else $error("protect bits changed with write protect low");
  // the mirror reloads after a reset release; that is no write
  a_bp_needs_latch: assert property ($changed(o_status[3:2]) && $past(i_rstn, 2)
    |-> $past(o_status[1]))
    else $error("protect bits changed without latch");
  a_latch_in_frame: assert property ($rose(o_status[1]) |-> !$past(i_pins.cs_n, 2))
    else $error("latch set outside a frame");
  a_so_after_fall: assert property (!o_so_oe_n && $changed(o_so) |-> fall_age_reg <= 4'h7)
    else $error("serial output moved away from a clock fall");
endmodule : snv_core_monitor

bind snv_core snv_core_monitor u_monitor (
  .i_clk     (i_clk),
  .i_rstn    (i_rstn),
  .i_pins    (i_pins),
  .o_so      (o_so),
  .o_so_oe_n (o_so_oe_n),
  .o_status  (o_status)
);

/* File: snv_host_model.sv */
/*
  host controller model: drives the memory pins in spi mode 0.
  assumes i_clk of 50 ns; sck period is 8 clocks (400 ns).
*/
`timescale 1ns/1ps

module snv_host_model (
  input  wire logic          i_clk,
  input  wire logic          i_so,
  input  wire logic          i_so_oe_n,
  output snv_pkg::snv_pins_s o_pins
);
  import snv_pkg::*;

  logic last_bit;

  // deselected, clock low, hold and write protect inactive
  initial begin
    o_pins = 5'h13;
    last_bit = 1'b0;
  end

  // one byte msb first; the read bit is taken at the end of the high phase,
  // since the output moves a few clocks after each fall
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge i_clk) o_pins.si <= tx[i];
      repeat (3) @(posedge i_clk);
      o_pins.sck <= 1'b1;
      repeat (4) @(posedge i_clk);
      rx[i] = i_so_oe_n ? ~last_bit : i_so; // released line never looks valid
      last_bit = rx[i];
      o_pins.sck <= 1'b0;
    end
  endtask : xbyte

  task automatic start;
    @(posedge i_clk) o_pins.cs_n <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : start

  // select rises a full period after the last fall
  task automatic stop;
    repeat (8) @(posedge i_clk);
    o_pins.cs_n <= 1'b1;
    repeat (16) @(posedge i_clk);
  endtask : stop

  // hold edges only with sck low; clock keeps toggling meanwhile
  task automatic pause;
    @(posedge i_clk) o_pins.hold_n <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      repeat (4) @(posedge i_clk);
      o_pins.sck <= ~o_pins.sck;
    end
    repeat (6) @(posedge i_clk);
    o_pins.hold_n <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask : pause
endmodule : snv_host_model

/* File: snv_core_tb.sv */
/*
  self-checking bench of snv_core driven through the host model.
  assumes snv_pkg, snv_core, the monitor and the host model are compiled.
*/
`timescale 1ns/1ps

module snv_core_tb;
  import snv_pkg::*;

  logic       i_clk;
  logic       i_rstn;
  logic       o_so;
  logic       o_so_oe_n;
  logic [7:0] o_status;
  logic [7:0] rx;
  snv_pins_s  pins;
  logic [7:0] mem [0:511];
  logic [1:0] bp;
  logic       lat;
  int         num_errors;
  int         checks_done;

  snv_core u_snv_core (.i_clk(i_clk), .i_rstn(i_rstn), .i_pins(pins), .o_so(o_so),
                       .o_so_oe_n(o_so_oe_n), .o_status(o_status));
  snv_host_model u_host (.i_clk(i_clk), .i_so(o_so), .i_so_oe_n(o_so_oe_n), .o_pins(pins));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up;
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  function automatic logic prot(input logic [1:0] b, input logic [8:0] a);
    return (b == 2'h3) || (b == 2'h2 && a >= 9'h100) || (b == 2'h1 && a >= 9'h180);
  endfunction : prot

  task automatic cmd(input logic [7:0] op);
    u_host.start;
    u_host.xbyte(op, rx);
    u_host.stop;
    if (op == 8'h06) lat = 1'b1;
    if (op == 8'h04) lat = 1'b0;
  endtask : cmd

  task automatic status_write_cmd(input logic [7:0] v);
    cmd(8'h06);
    u_host.start;
    u_host.xbyte(8'h01, rx);
    u_host.xbyte(v, rx);
    u_host.stop;
    if (pins.wp_n) bp = v[3:2];
    lat = 1'b0;
  endtask : status_write_cmd

  task automatic status_read_cmd;
    u_host.start;
    u_host.xbyte(8'h05, rx);
    u_host.xbyte(8'hff, rx);
    u_host.stop;
    chk("status read", {4'h0, bp, lat, 1'b0}, rx);
    chk("status port", {4'h0, bp, lat, 1'b0}, o_status);
  endtask : status_read_cmd

  task automatic wrmem(input logic [8:0] a, input logic [7:0] d, input int n);
    u_host.start;
    u_host.xbyte({4'h0, a[8], 3'h2}, rx);
    u_host.xbyte(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      u_host.xbyte(d + 8'(i), rx);
      if (lat && pins.wp_n && !prot(bp, a)) mem[a] = d + 8'(i);
      a = a + 9'h1;
    end
    u_host.stop;
    lat = 1'b0;
  endtask : wrmem

  task automatic rdmem(input logic [8:0] a, input int n, input int hold_at);
    u_host.start;
    u_host.xbyte({4'h0, a[8], 3'h3}, rx);
    u_host.xbyte(a[7:0], rx);
    for (int i = 0; i < n; i++) begin
      if (i == hold_at) u_host.pause;
      u_host.xbyte(8'hff, rx);
      chk("read data", mem[a], rx);
      a = a + 9'h1;
    end
    u_host.stop;
  endtask : rdmem

  // latch set, clear, and fixed bits of the status byte
  task automatic t_status;
    status_write_cmd(8'hf3);
    status_read_cmd;
    cmd(8'h06);
    status_read_cmd;
    cmd(8'h04);
    status_read_cmd;
    status_write_cmd(8'hff);
    status_read_cmd;
  endtask : t_status

  // every protect code against both sides of each boundary
  task automatic t_protect;
    logic [8:0] addrs [4] = '{9'h0ff, 9'h17f, 9'h180, 9'h1ff};
    for (int c = 0; c < 4; c++) begin
      status_write_cmd({4'h0, 2'(c), 2'h0});
      for (int k = 0; k < 4; k++) begin
        cmd(8'h06);
        wrmem(addrs[k], {2'(c), 6'(k)}, 1);
        rdmem(addrs[k], 1, -1);
      end
    end
    status_write_cmd(8'h04);
    cmd(8'h06);
    wrmem(9'h17f, 8'h77, 2);
    rdmem(9'h17f, 2, -1);
  endtask : t_protect

  // burst across the top of memory, read back with a hold mid-stream
  task automatic t_wrap;
    status_write_cmd(8'h00);
    cmd(8'h06);
    wrmem(9'h1ff, 8'ha0, 3);
    rdmem(9'h1ff, 3, 1);
  endtask : t_wrap

  // no latch, then write protect low, both refuse writes
  task automatic t_guard;
    wrmem(9'h000, 8'h5a, 1);
    rdmem(9'h000, 1, -1);
    @(posedge i_clk) u_host.o_pins.wp_n <= 1'b0;
    status_write_cmd(8'h0c);
    status_read_cmd;
    cmd(8'h06);
    wrmem(9'h001, 8'h3c, 1);
    rdmem(9'h001, 1, -1);
    @(posedge i_clk) u_host.o_pins.wp_n <= 1'b1;
    wrmem(9'h001, 8'h3c, 1);
    rdmem(9'h001, 1, -1);
  endtask : t_guard

  // protect bits survive a reset, the latch does not
  task automatic t_reset;
    status_write_cmd(8'h08);
    cmd(8'h06);
    @(posedge i_clk) i_rstn <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    lat = 1'b0;
    repeat (5) @(posedge i_clk);
    status_read_cmd;
  endtask : t_reset

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial begin
    num_errors = 0;
    checks_done = 0;
    lat = 1'b0;
    bp = 2'h0;
    i_rstn = 1'b0;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (5) @(posedge i_clk);
    t_status;
    t_protect;
    t_wrap;
    t_guard;
    t_reset;
    wrap_up;
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge i_clk);
    num_errors++;
    wrap_up;
  end
endmodule : snv_core_tb
